// [mrps_point_server.v]
// Modbus RTU point server: decode, map check, replies, password gating
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "mrps_map.vh"
module mrps_point_server #(
   parameter MINUTE_CYC = `MRPS_MINUTE_CYC,
   parameter NIN = 16
) (
   input wire sys_clk,
   input wire rst_b,
   input wire clk_en,
   // Decoded request from the frame layer
   input wire req_valid,
   input wire [7:0] req_func,
   input wire [15:0] req_addr,
   input wire [15:0] req_count,
   input wire [15:0] req_value,
   input wire rx_activity,
   input wire session_start,
   // Point sources
   input wire [24:0] coil_state,
   input wire [NIN-1:0] phys_in,
   input wire [15:0] meas_ia,
   input wire [15:0] meas_ib,
   input wire [15:0] meas_ic,
   input wire [15:0] meas_va_or_therm,
   input wire therm_model,
   // Reply toward the frame layer
   output reg rsp_valid_q,
   output reg [7:0] rsp_func_q,
   output reg rsp_exc_q,
   output reg [7:0] rsp_exc_code_q,
   output reg [15:0] rsp_data_q,
   // Command pulses, and the held ground block level
   output reg cmd_brk_open_q,
   output reg cmd_brk_close_q,
   output reg cmd_rcl_unlock_q,
   output reg cmd_rcl_lock_q,
   output reg cmd_dist_reset_q,
   output reg [2:0] cmd_group_q,
   output reg gnd_block_q,
   // Register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata_q,
   output wire irq
);
   ////////////////////////////////////////////////////////////////////////
   reg rear_password_enable_q;
   reg [10:0] rear_inactivity_timeout_q;
   reg [NIN-1:0] invert_q;
   reg unlocked_q;
   // Wide enough for one minute of sys_clk cycles
   reg [35:0] idle_cyc_q;
   reg [10:0] idle_min_q;
   reg [3:0] irq_st_q;
   reg [3:0] irq_mask_q;
   wire [NIN-1:0] din_mapped;
   wire minute_tick = (idle_cyc_q == MINUTE_CYC - 1);
   wire timed_out = minute_tick &&
      (idle_min_q + 11'd1 >= rear_inactivity_timeout_q);

   mrps_invert #(.W(NIN)) u_inv (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .raw_in(phys_in),
      .invert(invert_q),
      .mapped_q(din_mapped)
   );

   ////////////////////////////////////////////////////////////////////////
   // Request decode
   reg exc;
   reg [7:0] exc_code;
   reg [15:0] data;
   reg [15:0] last;
   reg [4:0] coil_idx;
   reg [15:0] therm;
   reg is_cmd;
   // Spans are checked start to end, with a wrap guard
   always @* begin
      exc = 1'b0;
      exc_code = `MRPS_EXC_FUNC;
      data = 16'h0000;
      last = req_addr + req_count - 16'h0001;
      coil_idx = req_addr[4:0] - 5'h00;
      therm = (meas_va_or_therm > `MRPS_THERM_MAX) ?
         `MRPS_THERM_MAX : meas_va_or_therm;
      is_cmd = 1'b0;
      case (req_func)
         `MRPS_FC_RD_COIL: begin
            if (req_count == 16'h0000 || req_addr < `MRPS_COIL_FIRST ||
               last > `MRPS_COIL_LAST || last < req_addr) begin
               exc = 1'b1;
               exc_code = `MRPS_EXC_ADDR;
            end else begin
               // Bit order follows the map: breaker, recloser, aux, groups
               data = {15'h0000, coil_state[coil_idx]};
            end
         end
         `MRPS_FC_RD_DIN: begin
            if (req_count == 16'h0000 || last > `MRPS_DIN_LAST ||
               last < req_addr) begin
               exc = 1'b1;
               exc_code = `MRPS_EXC_ADDR;
            end else begin
               data = din_mapped >> req_addr[3:0];
            end
         end
         `MRPS_FC_RD_IREG: begin
            if (req_count == 16'h0000 || req_addr < `MRPS_IREG_FIRST ||
               last > `MRPS_IREG_LAST || last < req_addr) begin
               exc = 1'b1;
               exc_code = `MRPS_EXC_ADDR;
            end else begin
               case (req_addr[1:0])
                  2'h0: data = meas_ia;
                  2'h1: data = meas_ib;
                  2'h2: data = meas_ic;
                  default: data = therm_model ? therm : meas_va_or_therm;
               endcase
            end
         end
         `MRPS_FC_WR_COIL: begin
            if (req_addr < `MRPS_CMD_BRK || req_addr > `MRPS_CMD_GND) begin
               exc = 1'b1;
               exc_code = `MRPS_EXC_ADDR;
            end else if (req_value != `MRPS_VAL_ON &&
               req_value != `MRPS_VAL_OFF) begin
               exc = 1'b1;
               exc_code = `MRPS_EXC_VALUE;
            end else if (req_value == `MRPS_VAL_OFF &&
               req_addr >= `MRPS_CMD_DIST && req_addr <= `MRPS_CMD_GRP3) begin
               // These points have only an ON action
               exc = 1'b1;
               exc_code = `MRPS_EXC_ADDR;
            end else begin
               is_cmd = 1'b1;
               data = req_value;
            end
         end
         default: begin
            exc = 1'b1;
            exc_code = `MRPS_EXC_FUNC;
         end
      endcase
   end

   // Locked sessions are silently dropped, like a missing password
   wire allowed = !rear_password_enable_q || unlocked_q;
   wire take = clk_en && req_valid && allowed;
   wire on = (req_value == `MRPS_VAL_ON);
   // Offset from the first group point; only 0 to 2 reach the shift
   wire [15:0] grp_off = req_addr - `MRPS_CMD_GRP1;

   ////////////////////////////////////////////////////////////////////////
   // Reply and command outputs
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         rsp_valid_q <= 1'b0;
         rsp_func_q <= 8'h00;
         rsp_exc_q <= 1'b0;
         rsp_exc_code_q <= 8'h00;
         rsp_data_q <= 16'h0000;
         cmd_brk_open_q <= 1'b0;
         cmd_brk_close_q <= 1'b0;
         cmd_rcl_unlock_q <= 1'b0;
         cmd_rcl_lock_q <= 1'b0;
         cmd_dist_reset_q <= 1'b0;
         cmd_group_q <= 3'h0;
         gnd_block_q <= 1'b0;
      end else if (clk_en) begin
         rsp_valid_q <= take;
         cmd_brk_open_q <= 1'b0;
         cmd_brk_close_q <= 1'b0;
         cmd_rcl_unlock_q <= 1'b0;
         cmd_rcl_lock_q <= 1'b0;
         cmd_dist_reset_q <= 1'b0;
         cmd_group_q <= 3'h0;
         if (take) begin
            rsp_exc_q <= exc;
            rsp_exc_code_q <= exc ? exc_code : 8'h00;
            rsp_func_q <= req_func | (exc ? 8'h80 : 8'h00);
            rsp_data_q <= data;
            if (is_cmd) begin
               case (req_addr)
                  `MRPS_CMD_BRK: begin
                     cmd_brk_open_q <= !on;
                     cmd_brk_close_q <= on;
                  end
                  `MRPS_CMD_RCL: begin
                     cmd_rcl_unlock_q <= !on;
                     cmd_rcl_lock_q <= on;
                  end
                  `MRPS_CMD_DIST: cmd_dist_reset_q <= 1'b1;
                  `MRPS_CMD_GND: gnd_block_q <= on;
                  default: cmd_group_q <= 3'b001 << grp_off[1:0];
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Inactivity lockout; the frame layer checks the password itself
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         unlocked_q <= 1'b0;
         idle_cyc_q <= 36'h0;
         idle_min_q <= 11'h000;
      end else if (clk_en) begin
         if (session_start || rx_activity) begin
            idle_cyc_q <= 36'h0;
            idle_min_q <= 11'h000;
            if (session_start) begin
               unlocked_q <= 1'b1;
            end
         end else if (unlocked_q) begin
            if (timed_out) begin
               unlocked_q <= 1'b0;
               idle_cyc_q <= 36'h0;
               idle_min_q <= 11'h000;
            end else if (minute_tick) begin
               idle_cyc_q <= 36'h0;
               idle_min_q <= idle_min_q + 11'd1;
            end else begin
               idle_cyc_q <= idle_cyc_q + 36'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port and interrupt
   // Events: 0 reply, 1 exception, 2 command, 3 lockout
   wire [3:0] ev = {unlocked_q && timed_out && clk_en && !session_start &&
      !rx_activity, take && is_cmd && !exc, take && exc, take};
   wire st_rd = clk_en && reg_rd && reg_addr == `MRPS_REG_IRQ_ST;
   assign irq = |(irq_st_q & irq_mask_q);
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         rear_password_enable_q <= 1'b0;
         rear_inactivity_timeout_q <= `MRPS_TIMEOUT_RST;
         invert_q <= {NIN{1'b0}};
         irq_st_q <= 4'h0;
         irq_mask_q <= 4'h0;
         reg_rdata_q <= 16'h0000;
      end else if (clk_en) begin
         // Set wins over the read clear
         irq_st_q <= (st_rd ? 4'h0 : irq_st_q) | ev;
         if (reg_wr) begin
            case (reg_addr)
               `MRPS_REG_CTRL:
                  rear_password_enable_q <= reg_wdata[`MRPS_CTRL_PWEN];
               // Out-of-range minutes are ignored, old period kept
               `MRPS_REG_TIMEOUT:
                  if (reg_wdata[10:0] >= 11'd1 && reg_wdata[10:0] <= 11'd1440)
                     rear_inactivity_timeout_q <= reg_wdata[10:0];
               `MRPS_REG_INVERT: invert_q <= reg_wdata[NIN-1:0];
               `MRPS_REG_IRQ_MASK: irq_mask_q <= reg_wdata[3:0];
               default: ;
            endcase
         end
         reg_rdata_q <= 16'h0000;
         if (reg_rd) begin
            case (reg_addr)
               `MRPS_REG_CTRL:
                  reg_rdata_q <= {15'h0000, rear_password_enable_q};
               `MRPS_REG_TIMEOUT:
                  reg_rdata_q <= {5'h00, rear_inactivity_timeout_q};
               `MRPS_REG_INVERT: reg_rdata_q <= invert_q;
               `MRPS_REG_STATUS:
                  reg_rdata_q <= {14'h0000, gnd_block_q, unlocked_q};
               `MRPS_REG_IRQ_ST: reg_rdata_q <= {12'h000, irq_st_q};
               `MRPS_REG_IRQ_MASK: reg_rdata_q <= {12'h000, irq_mask_q};
               default: reg_rdata_q <= 16'h0000;
            endcase
         end
      end
   end
endmodule // mrps_point_server

// [mrps_map.vh]
// Address map, codes and timing constants of the Modbus point server
`ifndef MRPS_MAP_VH
`define MRPS_MAP_VH
`define MRPS_FC_RD_COIL 8'h01
`define MRPS_FC_RD_DIN 8'h02
`define MRPS_FC_RD_IREG 8'h04
`define MRPS_FC_WR_COIL 8'h05
`define MRPS_EXC_FUNC 8'h01
`define MRPS_EXC_ADDR 8'h02
`define MRPS_EXC_VALUE 8'h03
`define MRPS_EXC_BIT 7
`define MRPS_COIL_FIRST 16'h0200
`define MRPS_COIL_LAST 16'h0218
`define MRPS_COIL_AUX 16'h0207
`define MRPS_COIL_VAUX 16'h020e
`define MRPS_COIL_GRP 16'h0215
`define MRPS_DIN_FIRST 16'h0000
`define MRPS_DIN_LAST 16'h000f
`define MRPS_IREG_FIRST 16'h2000
`define MRPS_IREG_LAST 16'h2003
`define MRPS_CMD_BRK 16'h0200
`define MRPS_CMD_RCL 16'h0201
`define MRPS_CMD_DIST 16'h0202
`define MRPS_CMD_GRP1 16'h0203
`define MRPS_CMD_GRP3 16'h0205
`define MRPS_CMD_GND 16'h0206
`define MRPS_VAL_OFF 16'h0000
`define MRPS_VAL_ON 16'hff00
`define MRPS_THERM_MAX 16'h7ff8
`define MRPS_THERM_PCT 240
// Register port offsets
`define MRPS_REG_CTRL 4'h0
`define MRPS_REG_TIMEOUT 4'h1
`define MRPS_REG_INVERT 4'h2
`define MRPS_REG_STATUS 4'h3
`define MRPS_REG_IRQ_ST 4'h4
`define MRPS_REG_IRQ_MASK 4'h5
`define MRPS_REG_UNLOCK 4'h6
`define MRPS_CTRL_PWEN 0
`define MRPS_TIMEOUT_RST 11'd1440
// One minute in ns needs 36 bits; a plain literal would be cut to 32
`define MRPS_MINUTE_NS 36'hdf8475800
`define MRPS_CLK_NS 50
`define MRPS_MINUTE_CYC (`MRPS_MINUTE_NS / `MRPS_CLK_NS)
`endif

// [mrps_invert.v]
// Per-input direct or inverted mapping stage, registered
`timescale 1ns/1ps
module mrps_invert #(
   parameter W = 16
) (
   input wire sys_clk,
   input wire rst_b,
   input wire clk_en,
   input wire [W-1:0] raw_in,
   input wire [W-1:0] invert,
   output reg [W-1:0] mapped_q
);
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         mapped_q <= {W{1'b0}};
      end else if (clk_en) begin
         mapped_q <= raw_in ^ invert;
      end
   end
endmodule // mrps_invert

// [mrps_point_server_chk.sv]
// Port-level assertions for the Modbus point server
`timescale 1ns/1ps
module mrps_point_server_chk (
   input wire sys_clk,
   input wire rst_b,
   input wire req_valid,
   input wire [7:0] req_func,
   input wire [15:0] req_addr,
   input wire [15:0] req_value,
   input wire rsp_valid_q,
   input wire [7:0] rsp_func_q,
   input wire rsp_exc_q,
   input wire [7:0] rsp_exc_code_q,
   input wire cmd_brk_close_q,
   input wire gnd_block_q
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // A locked session gives no reply, so silence is allowed
   wire f1 = req_valid && req_func == 8'h01;
   wire f5 = req_valid && req_func == 8'h05;
   a_reply_cause: assert property (rsp_valid_q |-> $past(req_valid))
      else $error("reply without request");
   a_exc_form: assert property (rsp_valid_q && rsp_exc_q |->
      rsp_func_q[7] && rsp_exc_code_q != 8'h00) else $error("bad exc form");
   a_bad_func: assert property (req_valid && !(req_func inside
      {8'h01, 8'h02, 8'h04, 8'h05}) |=> !rsp_valid_q ||
      rsp_exc_code_q == 8'h01) else $error("bad func code");
   a_coil_range: assert property (f1 && (req_addr < 16'h0200 ||
      req_addr > 16'h0218) |=> !rsp_valid_q || rsp_exc_code_q == 8'h02)
      else $error("coil range");
   a_din_range: assert property (req_valid && req_func == 8'h02 &&
      req_addr > 16'h000f |=> !rsp_valid_q || rsp_exc_code_q == 8'h02)
      else $error("input range");
   a_ireg_range: assert property (req_valid && req_func == 8'h04 &&
      req_addr > 16'h2003 |=> !rsp_valid_q || rsp_exc_code_q == 8'h02)
      else $error("register range");
   a_bad_value: assert property (f5 && req_addr >= 16'h0200 &&
      req_addr <= 16'h0206 && req_value != 16'h0000 && req_value != 16'hff00
      |=> !rsp_valid_q || rsp_exc_code_q == 8'h03) else $error("bad value");
   a_gnd_block: assert property (f5 && req_addr == 16'h0206 &&
      req_value == 16'hff00 |=> !rsp_valid_q || gnd_block_q)
      else $error("ground block");
   a_close_cause: assert property (cmd_brk_close_q |-> $past(req_valid)
      && $past(req_addr) == 16'h0200 && $past(req_value) == 16'hff00)
      else $error("close without cause");
endmodule // mrps_point_server_chk
bind mrps_point_server mrps_point_server_chk u_chk (.sys_clk(sys_clk),
   .rst_b(rst_b), .req_valid(req_valid), .req_func(req_func),
   .req_addr(req_addr), .req_value(req_value), .rsp_valid_q(rsp_valid_q),
   .rsp_func_q(rsp_func_q), .rsp_exc_q(rsp_exc_q),
   .rsp_exc_code_q(rsp_exc_code_q), .cmd_brk_close_q(cmd_brk_close_q),
   .gnd_block_q(gnd_block_q));

// [mrps_master.sv]
// Remote Modbus master model presenting decoded requests
`timescale 1ns/1ps
module mrps_master (
   input wire sys_clk,
   output reg req_valid = 1'b0,
   output reg [7:0] req_func = 8'h00,
   output reg [15:0] req_addr = 16'h0000,
   output reg [15:0] req_count = 16'h0001,
   output reg [15:0] req_value = 16'h0000,
   output reg rx_activity = 1'b0,
   output reg session_start = 1'b0
);
   task send(input [7:0] f, input [15:0] a, input [15:0] vl);
      begin
         @(posedge sys_clk);
         req_valid <= 1'b1;
         rx_activity <= 1'b1;
         req_func <= f;
         req_addr <= a;
         req_value <= vl;
         @(posedge sys_clk);
         req_valid <= 1'b0;
         rx_activity <= 1'b0;
         // Junk once gone, so stale fields are never trusted
         req_func <= ~f;
         req_addr <= ~a;
         req_value <= ~vl;
         #1;
      end
   endtask
   // Eight-character password judged upstream, success only
   task open_session;
      begin
         @(posedge sys_clk);
         session_start <= 1'b1;
         @(posedge sys_clk);
         session_start <= 1'b0;
      end
   endtask
endmodule // mrps_master

// [tb_mrps_point_server.sv]
// Self-checking testbench of the Modbus point server
`timescale 1ns/1ps
module tb_mrps_point_server;
   reg sys_clk = 1'b0;
   reg rst_b = 1'b0;
   reg th = 1'b0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [3:0] ra = 4'h0;
   reg [15:0] rw = 16'h0000;
   reg [24:0] coil = 25'h1a04085;
   reg [15:0] pin = 16'ha5c3;
   reg [15:0] mv = 16'h0123;
   reg [15:0] v;
   reg a;
   integer n_mismatch = 0;
   integer n_checks = 0;
   integer i;
   wire rv, rx, ss, qv, ex, irq, bo, bc, ru, rl, dr, gb;
   wire [7:0] rf, fc, ec;
   wire [15:0] ad, cn, val, dat, rdat;
   wire [2:0] grp;
   mrps_master u_mrps_master (.sys_clk(sys_clk), .req_valid(qv),
      .req_func(rf), .req_addr(ad), .req_count(cn), .req_value(val),
      .rx_activity(rx), .session_start(ss));
   mrps_point_server #(.MINUTE_CYC(10)) u_mrps_point_server (
      .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .req_valid(qv),
      .req_func(rf), .req_addr(ad), .req_count(cn), .req_value(val),
      .rx_activity(rx), .session_start(ss), .coil_state(coil),
      .phys_in(pin), .meas_ia(16'h0a01), .meas_ib(16'h0a02),
      .meas_ic(16'h0a03), .meas_va_or_therm(mv), .therm_model(th),
      .rsp_valid_q(rv), .rsp_func_q(fc), .rsp_exc_q(ex),
      .rsp_exc_code_q(ec), .rsp_data_q(dat), .cmd_brk_open_q(bo),
      .cmd_brk_close_q(bc), .cmd_rcl_unlock_q(ru), .cmd_rcl_lock_q(rl),
      .cmd_dist_reset_q(dr), .cmd_group_q(grp), .gnd_block_q(gb),
      .reg_addr(ra), .reg_wdata(rw), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata_q(rdat), .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask
   task req(input [7:0] f, input [15:0] ai, input [15:0] vl, input [7:0] e);
      begin
         u_mrps_master.send(f, ai, vl);
         chk(rv, 1'b1);
         chk(fc, (e != 8'h00) ? {1'b1, f[6:0]} : f);
         chk(ex, e != 8'h00);
         chk(ec, e);
      end
   endtask
   task rwr(input [3:0] ai, input [15:0] d);
      begin
         @(posedge sys_clk);
         ra <= ai;
         rw <= d;
         wr <= 1'b1;
         @(posedge sys_clk);
         wr <= 1'b0;
      end
   endtask
   task rrd(input [3:0] ai);
      begin
         @(posedge sys_clk);
         ra <= ai;
         rd <= 1'b1;
         @(posedge sys_clk);
         rd <= 1'b0;
         #1 v = rdat;
      end
   endtask
   task cmd(input [15:0] ai, input [15:0] vl, input [7:0] pv);
      begin
         req(8'h05, ai, vl, 8'h00);
         chk(dat, vl);
         chk({bo, bc, ru, rl, dr, grp}, pv);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_maps;
      begin
         req(8'h03, 16'h0200, 16'h0000, 8'h01);
         req(8'h06, 16'h0200, 16'h0000, 8'h01);
         req(8'h81, 16'h0200, 16'h0000, 8'h01);
         for (i = 0; i < 25; i = i + 1) begin
            req(8'h01, 16'h0200 + i[15:0], 16'h0000, 8'h00);
            chk(dat[0], coil[i]);
         end
         req(8'h01, 16'h0219, 16'h0000, 8'h02);
         req(8'h01, 16'h01ff, 16'h0000, 8'h02);
         for (i = 0; i < 16; i = i + 1) begin
            req(8'h02, i[15:0], 16'h0000, 8'h00);
            chk(dat[0], pin[i]);
         end
         req(8'h02, 16'h0010, 16'h0000, 8'h02);
         rwr(4'h2, 16'h0001);
         req(8'h02, 16'h0000, 16'h0000, 8'h00);
         chk(dat[0], !pin[0]);
         for (i = 0; i < 3; i = i + 1) begin
            req(8'h04, 16'h2000 + i[15:0], 16'h0000, 8'h00);
            chk(dat, 16'h0a01 + i[15:0]);
         end
         req(8'h04, 16'h2003, 16'h0000, 8'h00);
         chk(dat, 16'h0123);
         @(posedge sys_clk);
         th <= 1'b1;
         mv <= 16'h9000;
         req(8'h04, 16'h2003, 16'h0000, 8'h00);
         chk(dat, 16'h7ff8);
         req(8'h04, 16'h2004, 16'h0000, 8'h02);
      end
   endtask
   task t_force;
      begin
         cmd(16'h0200, 16'h0000, 8'h80);
         cmd(16'h0200, 16'hff00, 8'h40);
         cmd(16'h0201, 16'h0000, 8'h20);
         cmd(16'h0201, 16'hff00, 8'h10);
         cmd(16'h0202, 16'hff00, 8'h08);
         for (i = 0; i < 3; i = i + 1)
            cmd(16'h0203 + i[15:0], 16'hff00, 8'h01 << i);
         cmd(16'h0206, 16'hff00, 8'h00);
         chk(gb, 1'b1);
         rrd(4'h3);
         chk(v, 16'h0002);
         cmd(16'h0206, 16'h0000, 8'h00);
         chk(gb, 1'b0);
         req(8'h05, 16'h0203, 16'h1234, 8'h03);
         req(8'h05, 16'h0207, 16'hff00, 8'h02);
         req(8'h05, 16'h0204, 16'h0000, 8'h02);
      end
   endtask
   task t_lock;
      begin
         rrd(4'h1);
         chk(v, 16'd1440);
         rwr(4'h1, 16'h0000);
         rrd(4'h1);
         chk(v, 16'h05a0);
         rwr(4'h1, 16'h0001);
         rwr(4'h0, 16'h0001);
         u_mrps_master.send(8'h01, 16'h0200, 16'h0000);
         chk(rv, 1'b0);
         u_mrps_master.open_session;
         req(8'h01, 16'h0200, 16'h0000, 8'h00);
         repeat (25) @(posedge sys_clk);
         u_mrps_master.send(8'h01, 16'h0200, 16'h0000);
         chk(rv, 1'b0);
         rwr(4'h5, 16'h0000);
         #1 a = irq;
         rwr(4'h5, 16'hffff);
         #1 chk(irq ^ a, 1'b1);
         rrd(4'h4);
         chk(v[3], 1'b1);
         chk(irq, 1'b0);
         rrd(4'h4);
         chk(v, 16'h0000);
         rrd(4'hf);
         chk(v, 16'h0000);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_maps;
      t_force;
      t_lock;
      tally_and_finish;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
   end
endmodule // tb_mrps_point_server
